// File: pkg/fpm_pkg.sv
// Purpose: shared constants of the fifo phase monitor
// Assumes: 8-bit register port with 5-bit addresses
// Notes:   offsets, field positions and control/offset reset values live here; other resets are fixed in the modules
package fpm_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [4:0] FPM_ADDR_STATUS  = 5'h07;
  localparam logic [4:0] FPM_ADDR_CONTROL = 5'h08;
  // status fields
  localparam int FPM_ST_POS_LSB = 4;
  localparam int FPM_ST_ERR     = 7;
  localparam int FPM_ST_VALID   = 3;
  localparam int FPM_ST_CHANGE  = 2;
  localparam int FPM_ST_OFF_LSB = 0;
  // control fields
  localparam int FPM_CT_WATCH   = 7;
  localparam int FPM_CT_AUTO    = 6;
  localparam int FPM_CT_LEN_LSB = 2;
  localparam int FPM_CT_THR     = 0;
  localparam logic [7:0] FPM_CT_MASK  = 8'hfd;
  localparam logic [7:0] FPM_CT_RESET = 8'h00;
  localparam logic [1:0] FPM_OFF_RESET = 2'h0;
  // ----------------------------------------------------------------
  // filter and position
  // ----------------------------------------------------------------
  localparam logic [3:0] FPM_LEN_MAX = 4'hc;
  localparam int         FPM_FRAC    = 12;
  localparam logic [2:0] FPM_CENTER  = 3'h4;
  localparam logic [2:0] FPM_POS_MIN = 3'h0;
  localparam logic [2:0] FPM_POS_MAX = 3'h7;
  localparam logic [2:0] FPM_POS_LO1 = 3'h1;
  localparam logic [2:0] FPM_POS_HI1 = 3'h6;
  // cycles between two measurements
  localparam int FPM_MEAS_PERIOD = 16;

  // position lies in the drift band chosen by the threshold bit
  function automatic logic fpm_alarm(input logic [2:0] pos, input logic thr);
    logic edge_pos;
    edge_pos = (pos == FPM_POS_MIN) || (pos == FPM_POS_MAX);
    return edge_pos || (thr && ((pos == FPM_POS_LO1) || (pos == FPM_POS_HI1)));
  endfunction

  function automatic logic [2:0] fpm_gray2bin(input logic [2:0] g);
    return {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
  endfunction
endpackage

// File: rtl/fpm_ptr_sync.sv
// Purpose: fifo write counter on the link clock, carried into clk as gray code
// Assumes: link clock runs whenever the data source sends samples
// Notes:   output lags the true pointer by two or three clk cycles
`timescale 1ns/10ps
`default_nettype none
module fpm_ptr_sync
  import fpm_pkg::*;
(
  input  wire logic       link_clk,
  input  wire logic       clk,
  input  wire logic       rst,
  output logic [2:0]      wr_pos
);
  // ----------------------------------------------------------------
  // link domain: gray write counter
  // ----------------------------------------------------------------
  logic [2:0] wr_bin_ff;
  logic [2:0] wr_gray_ff;
  logic [2:0] nxt_wr_bin;

  assign nxt_wr_bin = wr_bin_ff + 3'h1;

  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      wr_bin_ff  <= 3'h0;
      wr_gray_ff <= 3'h0;
    end else begin
      wr_bin_ff  <= nxt_wr_bin;
      wr_gray_ff <= nxt_wr_bin ^ (nxt_wr_bin >> 1);
    end
  end

  // ----------------------------------------------------------------
  // clk domain: two flops, one bit changes per step
  // ----------------------------------------------------------------
  logic [2:0] gray_s1_ff;
  logic [2:0] gray_s2_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gray_s1_ff <= 3'h0;
      gray_s2_ff <= 3'h0;
    end else begin
      gray_s1_ff <= wr_gray_ff;
      gray_s2_ff <= gray_s1_ff;
    end
  end

  assign wr_pos = fpm_gray2bin(gray_s2_ff);
endmodule // fpm_ptr_sync
`default_nettype wire

// File: rtl/fpm_monitor.sv
// Purpose: watches the alignment fifo between data clock and converter clock
// Assumes: register port and sync_irq_enable are in the clk domain
// Notes:   read counter steps once per clk; position is write minus read
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - status gives read position and sync error
// - valid flag rises after first measurement
// - change flag marks differing status while watching
// - watching measures repeatedly, alarms beyond threshold
// - auto mode, with watching on and sync irq off, recenters read counter from measurement
// - offset field writes counter, reads measured/applied
module fpm_monitor
  import fpm_pkg::*;
#(
  parameter int MEAS_PERIOD = FPM_MEAS_PERIOD
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       link_clk,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic       sync_irq_enable,
  output logic [2:0]      fifo_read_ptr,
  output logic            drift_alarm
);
  // refused at elaboration: the timer is 16 bits wide
  if (MEAS_PERIOD < 4 || MEAS_PERIOD > 65535) begin : g_bad_period
    $error("MEAS_PERIOD must lie in 4..65535");
  end

  // ----------------------------------------------------------------
  // write pointer from the link domain
  // ----------------------------------------------------------------
  logic [2:0] wr_pos;

  fpm_ptr_sync u_ptr_sync (
    .link_clk (link_clk),
    .clk      (clk),
    .rst      (rst),
    .wr_pos   (wr_pos)
  );

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [7:0] ctl_ff;
  logic       wr_ctl;
  logic       wr_stat;
  logic       watch;
  logic       auto_req;
  logic       auto_active;
  logic       thr_sel;
  logic [3:0] len_raw;
  logic [3:0] eff_len;

  assign wr_ctl   = reg_wr && (reg_addr == FPM_ADDR_CONTROL);
  assign wr_stat  = reg_wr && (reg_addr == FPM_ADDR_STATUS);
  assign watch    = ctl_ff[FPM_CT_WATCH];
  assign auto_req = ctl_ff[FPM_CT_AUTO];
  assign thr_sel  = ctl_ff[FPM_CT_THR];
  assign len_raw  = ctl_ff[FPM_CT_LEN_LSB +: 4];
  // auto only works with watching on and the sync irq off
  assign auto_active = auto_req && watch && !sync_irq_enable;
  assign eff_len  = (len_raw > FPM_LEN_MAX) ? FPM_LEN_MAX : len_raw;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_ff <= FPM_CT_RESET;
    end else if (wr_ctl) begin
      ctl_ff <= reg_wdata & FPM_CT_MASK;
    end
  end

  // ----------------------------------------------------------------
  // measurement timer
  // ----------------------------------------------------------------
  logic [15:0] tmr_ff;
  logic        meas_tick;

  assign meas_tick = (tmr_ff == 16'(MEAS_PERIOD - 1));

  // a first measurement always runs so that valid can rise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tmr_ff <= 16'h0;
    end else if (meas_tick) begin
      tmr_ff <= 16'h0;
    end else begin
      tmr_ff <= tmr_ff + 16'h1;
    end
  end

  // ----------------------------------------------------------------
  // read counter with offset
  // ----------------------------------------------------------------
  logic [2:0] rd_base_ff;
  logic [1:0] offset_ff;
  logic [2:0] raw_pos;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_base_ff <= 3'h0;
    end else begin
      rd_base_ff <= rd_base_ff + 3'h1;
    end
  end

  assign fifo_read_ptr = rd_base_ff + {1'b0, offset_ff};
  assign raw_pos       = wr_pos - fifo_read_ptr;

  // ----------------------------------------------------------------
  // averaging filter, 3 integer and 12 fraction bits
  // ----------------------------------------------------------------
  localparam int AW = 3 + FPM_FRAC;
  logic [AW-1:0]        acc_ff;
  logic signed [AW-1:0] delta;
  logic [AW-1:0]        nxt_acc;
  logic [2:0]           filt_pos;

  // modulo difference keeps the wrap of the 8-entry ring
  assign delta    = signed'({raw_pos, {FPM_FRAC{1'b0}}} - acc_ff);
  assign nxt_acc  = acc_ff + AW'(delta >>> eff_len);
  assign filt_pos = nxt_acc[AW-1:FPM_FRAC];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc_ff <= '0;
    end else if (meas_tick) begin
      acc_ff <= nxt_acc;
    end
  end

  // ----------------------------------------------------------------
  // status, valid, change, alarm
  // ----------------------------------------------------------------
  logic [3:0] stat_ff;
  logic [3:0] nxt_stat;
  logic       valid_ff;
  logic       change_ff;
  logic       alarm_ff;
  logic [1:0] meas_off_ff;

  assign nxt_stat = {fpm_alarm(filt_pos, thr_sel), filt_pos};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_ff <= 4'h0;
    end else if (meas_tick) begin
      stat_ff <= nxt_stat;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_ff <= 1'b0;
    end else if (meas_tick) begin
      valid_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      change_ff <= 1'b0;
    end else if (meas_tick) begin
      change_ff <= watch && valid_ff && (nxt_stat != stat_ff);
    end
  end

  // one-cycle pulse per measurement taken while watching that lands in the drift band
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      alarm_ff <= 1'b0;
    end else begin
      alarm_ff <= meas_tick && watch && nxt_stat[3];
    end
  end

  assign drift_alarm = alarm_ff;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meas_off_ff <= FPM_OFF_RESET;
    end else if (meas_tick && watch) begin
      meas_off_ff <= 2'(filt_pos - FPM_CENTER);
    end
  end

  // ----------------------------------------------------------------
  // offset: software write, auto recentering
  // ----------------------------------------------------------------
  // a write in the same cycle as an auto step wins: software is explicit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      offset_ff <= FPM_OFF_RESET;
    end else if (wr_stat) begin
      offset_ff <= reg_wdata[FPM_ST_OFF_LSB +: 2];
    end else if (meas_tick && auto_active && nxt_stat[3]) begin
      offset_ff <= offset_ff + 2'(filt_pos - FPM_CENTER);
    end
  end

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [7:0] rdata_ff;
  logic [1:0] off_view;

  assign off_view = auto_active ? offset_ff : (watch ? meas_off_ff : offset_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        FPM_ADDR_STATUS:  rdata_ff <= {stat_ff, valid_ff, change_ff, off_view};
        FPM_ADDR_CONTROL: rdata_ff <= ctl_ff;
        default:          rdata_ff <= 8'h00;
      endcase
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_tick_watch;
    meas_tick && watch;
  endsequence

  sequence s_tick_no_len;
    meas_tick && (eff_len == 4'h0);
  endsequence

  property p_err_bit;
    meas_tick |=> stat_ff[3] == fpm_alarm(stat_ff[2:0], $past(thr_sel));
  endproperty
  a_err_bit: assert property (p_err_bit) else $error("sync error bit mismatch");

  property p_stat_hold;
    !meas_tick |=> $stable(stat_ff);
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("status moved off tick");

  property p_valid_rise;
    $rose(valid_ff) |-> $past(meas_tick) ##1 valid_ff [*8];
  endproperty
  a_valid_rise: assert property (p_valid_rise) else $error("valid rose wrongly");

  property p_change_off;
    meas_tick && !watch |=> !change_ff;
  endproperty
  a_change_off: assert property (p_change_off) else $error("change set while not watching");

  property p_alarm;
    s_tick_watch ##0 nxt_stat[3] |=> drift_alarm ##1 !drift_alarm;
  endproperty
  a_alarm: assert property (p_alarm) else $error("drift alarm not pulsed");

  property p_alarm_cause;
    drift_alarm |-> $past(meas_tick) && $past(watch);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without watched tick");

  property p_no_auto;
    !auto_active && !wr_stat |=> $stable(offset_ff);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("offset moved without auto");

  property p_off_write;
    wr_stat |=> offset_ff == $past(reg_wdata[1:0]);
  endproperty
  a_off_write: assert property (p_off_write) else $error("offset write lost");

  property p_filter_pass;
    s_tick_no_len |=> stat_ff[2:0] == $past(raw_pos);
  endproperty
  a_filter_pass: assert property (p_filter_pass) else $error("unfiltered position wrong");

  property p_valid_hold;
    valid_ff |=> valid_ff;
  endproperty
  a_valid_hold: assert property (p_valid_hold) else $error("valid dropped without reset");

  property p_change_set;
    s_tick_watch ##0 (valid_ff && (nxt_stat != stat_ff)) |=> change_ff;
  endproperty
  a_change_set: assert property (p_change_set) else $error("status change not flagged");

  // step comes from the position measured at that same tick
  property p_auto_step;
    meas_tick && auto_active && nxt_stat[3] && !wr_stat |=>
      offset_ff == 2'($past(offset_ff) + 2'($past(filt_pos) - FPM_CENTER));
  endproperty
  a_auto_step: assert property (p_auto_step) else $error("auto offset step wrong");

  // release edge left out: the base counter is still held there
  property p_ptr_step;
    !rst && !wr_stat && !(meas_tick && auto_active) |=> fifo_read_ptr == 3'($past(fifo_read_ptr) + 3'h1);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("read counter did not step");
endmodule // fpm_monitor
`default_nettype wire

// File: sim/fpm_link_src.sv
// Purpose: data source side of the alignment fifo, supplies the link clock
// Assumes: source clock runs free, as the monitor expects
// Notes:   phase offset keeps it unrelated to clk
`timescale 1ns/10ps
`default_nettype none
module fpm_link_src #(
  parameter real HALF_NS = 62.5
) (
  output logic link_clk
);
  // ----------------------------------------------------------------
  // free running clock, no relation to the converter clock
  // ----------------------------------------------------------------
  initial begin
    link_clk = 1'b0;
    #7.3;
    forever #(HALF_NS) link_clk = ~link_clk;
  end
endmodule // fpm_link_src
`default_nettype wire

// File: sim/testbench.sv
// Purpose: register level tests of the fifo phase monitor
// Assumes: strobe register port, measurement every MEAS_PERIOD cycles
// Notes:   position drifts since link and converter clocks differ
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fpm_pkg::*;
  logic       clk;
  logic       rst;
  logic       link_clk;
  logic       reg_wr;
  logic       reg_rd;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic       sync_irq_enable;
  logic [2:0] fifo_read_ptr;
  logic       drift_alarm;
  int         errors;
  int         tests_run;
  logic [7:0] s;
  logic [2:0] p0;
  logic       seen;

  fpm_link_src i_src (.link_clk(link_clk));
  fpm_monitor #(.MEAS_PERIOD(16)) i_dut (
    .clk(clk), .rst(rst), .link_clk(link_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .sync_irq_enable(sync_irq_enable), .fifo_read_ptr(fifo_read_ptr), .drift_alarm(drift_alarm));

  always #10 clk = ~clk;

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (exp !== got) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // bounded wait on the alarm pulse, gives up after 801 cycles
  task automatic wait_alarm();
    int n;
    n = 0;
    #1;
    while (drift_alarm !== 1'b1 && n <= 800) begin
      @(posedge clk);
      #1 n++;
    end
    if (n > 800) begin
      chk("alarm wait", 8'h01, 8'h00);
      test_done();
    end
  endtask

  function automatic logic [7:0] in_band(input logic [2:0] pos, input logic thr);
    return {7'h0, (pos == 3'h0) || (pos == 3'h7) || (thr && (pos == 3'h1 || pos == 3'h6))};
  endfunction

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = 5'h00; reg_wdata = 8'h00; sync_irq_enable = 1'b1;
    errors = 0; tests_run = 0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    reg_read(FPM_ADDR_CONTROL, s);
    chk("control reset", 8'h00, s);
    reg_read(FPM_ADDR_STATUS, s);
    chk("valid before tick", 8'h00, {7'h0, s[3]});
    chk("offset reset", 8'h00, {6'h0, s[1:0]});
    @(posedge clk);
    #1 p0 = fifo_read_ptr;
    reg_write(FPM_ADDR_STATUS, 8'h02);
    #1 chk("read ptr step", {5'h0, p0 + 3'h4}, {5'h0, fifo_read_ptr});
    reg_read(FPM_ADDR_STATUS, s);
    chk("written offset", 8'h02, {6'h0, s[1:0]});
    $display("test reset and offset done");

    reg_write(FPM_ADDR_CONTROL, 8'hff);
    reg_read(FPM_ADDR_CONTROL, s);
    chk("control store", 8'hfd, s);
    reg_write(5'h09, 8'h55);
    reg_read(5'h09, s);
    chk("unmapped read", 8'h00, s);
    reg_write(FPM_ADDR_CONTROL, 8'h00);
    repeat (40) @(posedge clk);
    seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      reg_read(FPM_ADDR_STATUS, s);
      chk("valid after tick", 8'h01, {7'h0, s[3]});
      seen |= s[2];
      repeat (14) @(posedge clk);
      #1 seen |= drift_alarm;
    end
    chk("quiet when unwatched", 8'h00, {7'h0, seen});
    $display("test registers and idle done");

    for (int t = 0; t < 2; t++) begin
      reg_write(FPM_ADDR_CONTROL, {7'h40, t[0]});
      wait_alarm();
      reg_read(FPM_ADDR_STATUS, s);
      chk("sync error bit", 8'h01, {7'h0, s[7]});
      chk("alarm band", 8'h01, in_band(s[6:4], t[0]));
      chk("measured offset", {6'h0, 2'(s[6:4] - FPM_CENTER)}, {6'h0, s[1:0]});
    end
    seen = 1'b0;
    for (int i = 0; i < 12; i++) begin
      reg_read(FPM_ADDR_STATUS, s);
      seen |= s[2];
      repeat (14) @(posedge clk);
    end
    chk("change seen", 8'h01, {7'h0, seen});
    $display("test watch done");

    reg_write(FPM_ADDR_CONTROL, 8'hc0);
    wait_alarm();
    // written offset is hidden while auto is blocked: view shows the measurement
    reg_write(FPM_ADDR_STATUS, 8'h02);
    reg_read(FPM_ADDR_STATUS, s);
    chk("auto blocked view", {6'h0, 2'(s[6:4] - FPM_CENTER)}, {6'h0, s[1:0]});
    @(posedge clk);
    sync_irq_enable <= 1'b0;
    wait_alarm();
    reg_write(FPM_ADDR_STATUS, 8'h01);
    wait_alarm();
    reg_read(FPM_ADDR_STATUS, s);
    chk("auto step", {6'h0, 2'(2'h1 + 2'(s[6:4] - FPM_CENTER))}, {6'h0, s[1:0]});
    reg_read(FPM_ADDR_CONTROL, s);
    chk("auto control", 8'hc0, s);
    $display("test auto done");

    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_read(FPM_ADDR_STATUS, s);
    chk("valid after reset", 8'h00, {7'h0, s[3]});
    chk("offset after reset", 8'h00, {6'h0, s[1:0]});
    reg_read(FPM_ADDR_CONTROL, s);
    chk("control after reset", 8'h00, s);
    $display("test second reset done");
    test_done();
  end
endmodule // testbench
`default_nettype wire
